// *** hw/flk_pkg.sv ***
// flk_pkg: constants, field layouts and carrier types for the
// fractional-N loop control block.
// assumes a 10 MHz system clock and 32-bit serial words, address low.
package flk_pkg;
  localparam int CLK_PS = 100000;             // 100 ns period
  localparam int W_WORD = 32;
  localparam int W_FRAC = 22;
  localparam int W_NARROW = 10;
  localparam int W_RDIV = 12;
  // register addresses carried in word bits [3:0]
  localparam logic [3:0] ADR_R0 = 4'h0;
  localparam logic [3:0] ADR_R1 = 4'h1;
  localparam logic [3:0] ADR_DEN = 4'h2;
  localparam logic [3:0] ADR_CTL = 4'h3;
  // field positions within a serial word
  localparam int F_CTL = 4;
  localparam int F_DEN = 4;
  localparam int F_RDIV = 4;
  localparam int F_NUMH = 16;
  localparam int F_NUML = 4;
  localparam int W_NUMH = 7;
  localparam int W_NUML = 15;
  // encodings
  localparam logic [2:0] ORD_INT = 3'h0;
  localparam logic [2:0] ORD_FIRST = 3'h1;
  localparam logic [2:0] ORD_MAX = 3'h4;
  localparam logic [1:0] DITHER_OFF = 2'h3;
  localparam logic [3:0] MUX_HIZ = 4'h0;
  localparam logic [3:0] MUX_HIGH = 4'h1;
  localparam logic [3:0] MUX_LOW = 4'h2;
  localparam logic [3:0] MUX_LD = 4'h3;
  localparam logic [3:0] MUX_LDN = 4'h4;
  localparam logic [3:0] MUX_LDOD = 4'h5;
  localparam logic [3:0] MUX_DIAG_END = 4'hD;
  // lock detect
  localparam logic [2:0] LD_GOOD_N = 3'h5;
  localparam logic [7:0] LD_CNT_MAX = 8'hFE;
  localparam logic [15:0] LD_IDLE_MAX = 16'h03E8;
  localparam int LD_WIN_PS0 = 3000;
  localparam int LD_WIN_PS1 = 5500;
  localparam int LD_WIN_PS2 = 8000;
  localparam int LD_WIN_PS3 = 10500;
  localparam int LD_WIN_PS4 = 13000;
  localparam int LD_WIN_PS5 = 15500;
  // reset values
  localparam logic [W_RDIV-1:0] RST_RDIV = 12'h001;
  localparam logic [W_FRAC-1:0] RST_DEN = 22'h000000;

  typedef struct packed {
    logic [3:0] test_out_select;
    logic       fsk;
    logic [2:0] win;
    logic       tri_st;
    logic [1:0] dither;
    logic [2:0] ord;
    logic       wide;
    logic       dbl;
    logic       pol;
  } flk_ctl_t;

  localparam flk_ctl_t RST_CTL = '{test_out_select: MUX_HIZ, fsk: 1'b0, win: 3'h0,
    tri_st: 1'b0, dither: DITHER_OFF, ord: ORD_INT, wide: 1'b1, dbl: 1'b0,
    pol: 1'b0};

  typedef struct packed {
    logic [W_WORD-1:0] sh;
    logic              sclk_q;
    logic              le_q;
    logic              ref_q;
    flk_ctl_t          ctl;
    logic [W_FRAC-1:0] den;
    logic [W_FRAC-1:0] num;
    logic [W_RDIV-1:0] rdiv;
    logic [W_RDIV-1:0] rcnt;
    logic              pd_ref;
    logic [2:0]        ord_a;
    logic [1:0]        dither_a;
    logic              wide_a;
    logic [2:0]        ord_o;
    logic [1:0]        dither_o;
    logic              frac;
    logic [W_FRAC-1:0] num_o;
    logic [W_FRAC-1:0] den_o;
    logic              cal;
    logic              tst;
    logic              tst_oe;
  } flk_top_st_t;

  typedef struct packed {
    logic        pend_ref;
    logic        pend_fb;
    logic [7:0]  cnt;
    logic [2:0]  good;
    logic        locked;
    logic [15:0] idle;
  } flk_ld_st_t;

  // lock window in clock cycles, floored, never below one
  function automatic logic [7:0] flk_win_cyc(input logic [2:0] sel);
    int ps;
    ps = LD_WIN_PS0;
    case (sel)
      3'h1: ps = LD_WIN_PS1;
      3'h2: ps = LD_WIN_PS2;
      3'h3: ps = LD_WIN_PS3;
      3'h4: ps = LD_WIN_PS4;
      3'h5: ps = LD_WIN_PS5;
      default: ps = LD_WIN_PS0;
    endcase
    return (ps / CLK_PS < 1) ? 8'h01 : 8'(ps / CLK_PS);
  endfunction : flk_win_cyc
endpackage : flk_pkg

// *** hw/flk_lock_det.sv ***
// flk_lock_det: digital lock detector comparing reference and feedback
// divider pulses; assumes both are one-cycle pulses on I_CLK.
module flk_lock_det
  import flk_pkg::*;
#(
  parameter logic [15:0] IDLE_MAX = LD_IDLE_MAX
) (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_ref,
  input  wire logic       i_fb,
  input  wire logic [2:0] i_win,
  output logic            o_locked
);
  flk_ld_st_t s_r;
  flk_ld_st_t s_nxt;
  logic       closed;
  logic [7:0] off;
  logic [7:0] win;

  // pair the edges, grade each phase detector cycle, watch the reference
  always_comb begin
    s_nxt  = s_r;
    closed = 1'b0;
    off    = 8'h00;
    win    = flk_win_cyc(i_win);           // RULE14
    if (!(s_r.pend_ref | s_r.pend_fb)) begin
      if (i_ref && i_fb) begin
        closed = 1'b1;
      end else if (i_ref) begin
        s_nxt.pend_ref = 1'b1;
        s_nxt.cnt      = 8'h00;
      end else if (i_fb) begin
        s_nxt.pend_fb = 1'b1;
        s_nxt.cnt     = 8'h00;
      end
    end else if ((s_r.pend_ref && i_fb) || (s_r.pend_fb && i_ref) ||
                 s_r.cnt == LD_CNT_MAX) begin
      // a missing partner saturates and grades as far out of window
      closed         = 1'b1;
      off            = s_r.cnt + 8'h01;
      s_nxt.pend_ref = 1'b0;
      s_nxt.pend_fb  = 1'b0;
    end else begin
      s_nxt.cnt = s_r.cnt + 8'h01;
    end
    if (closed) begin
      if (!s_r.locked) begin
        if (off < win) begin
          if (s_r.good == LD_GOOD_N - 3'h1) begin
            s_nxt.locked = 1'b1;           // RULE11
            s_nxt.good   = 3'h0;
          end else begin
            s_nxt.good = s_r.good + 3'h1;
          end
        end else begin
          s_nxt.good = 3'h0;               // RULE21
        end
      end else if (off > win) begin
        s_nxt.locked = 1'b0;               // RULE12
      end
    end
    // a dead reference cannot leave a stale lock behind
    s_nxt.idle = i_ref ? 16'h0000 :
                 (s_r.idle == IDLE_MAX ? s_r.idle : s_r.idle + 16'h0001);
    if (s_r.idle == IDLE_MAX) begin
      s_nxt.locked = 1'b0;                 // RULE13
      s_nxt.good   = 3'h0;
    end
    if (i_srst) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    s_r <= s_nxt;
  end

  assign o_locked = s_r.locked;

  property p_lock_rise;
    @(posedge i_clk) disable iff (i_srst)
    $rose(s_r.locked) |-> $past(s_r.good) == LD_GOOD_N - 3'h1;
  endproperty
  a_lock_rise: assert property (p_lock_rise) // RULE11
    else $error("lock rose without five good cycles");

  property p_idle_unlock;
    @(posedge i_clk) disable iff (i_srst)
    (s_r.idle == IDLE_MAX) |=> !s_r.locked;
  endproperty
  a_idle_unlock: assert property (p_idle_unlock) // RULE13
    else $error("lock held with reference gone");

  property p_hold;
    @(posedge i_clk) disable iff (i_srst)
    (s_r.locked && s_r.idle != IDLE_MAX && !(closed && off > win))
      |=> s_r.locked;
  endproperty
  a_hold: assert property (p_hold) // RULE12
    else $error("lock dropped inside exit window");
endmodule : flk_lock_det

// *** hw/flk_top.sv ***
// flk_top: serial-programmed control of a fractional-N synthesizer
// loop: control word, denominator, dividers, lock detect, test pin.
// assumes serial pins and reference are synchronous to I_CLK.
// Summary of operation
// RULE1 - polarity bit clear drives pump positive, set drives negative
// RULE2 - doubler set doubles reference and bypasses reference divider
// RULE3 - wide fraction set uses 22 bits, clear uses low 10 bits
// RULE4 - host clears wide fraction before enabling shift keying
// RULE5 - order 0 integer, 1 to 4 modulator orders, 5-7 illegal
// RULE6 - first order applies no compensation and no dithering
// RULE7 - dither 0 weak, 1 medium, 2 strong, 3 off
// RULE8 - host keeps dither off in integer or first order
// RULE9 - host should disable dither when numerator is zero
// RULE10 - tri-state bit set floats pump, clear runs normally
// RULE11 - lock declared after five consecutive in-window cycles
// RULE12 - lock held until offset exceeds exit window
// RULE13 - lost reference reliably reports unlocked
// RULE14 - window select gives 3 to 15.5 ns, 6-7 reserved; code floors every select to a one-cycle (100 ns) window
// RULE15 - shift keying bit enables keying through feedback divider
// RULE16 - 22-bit denominator applied only in fractional mode
// RULE17 - any divider register write starts calibration on internal VCO
// RULE18 - 12-bit reference divider divides by 1 to 4095, 0 illegal
// RULE19 - 22-bit numerator split over two words, fractional only
// RULE20 - lock detect test mode drives high when locked
// RULE21 - unlocked bad cycle clears consecutive count
// RULE22 - mode changes apply at next phase detector cycle
module flk_top
  import flk_pkg::*;
#(
  parameter logic [15:0] IDLE_MAX = LD_IDLE_MAX
) (
  input  wire logic              I_CLK,
  input  wire logic              I_SRST,
  input  wire logic              I_SER_CLK,
  input  wire logic              I_SER_DATA,
  input  wire logic              I_SER_LE,
  input  wire logic              I_REF_IN,
  input  wire logic              I_FB_PULSE,
  input  wire logic              I_VCO_INTERNAL,
  output logic                   O_PUMP_POL,
  output logic                   O_PUMP_TRI,
  output logic                   O_PD_REF,
  output logic [2:0]             O_MOD_ORDER,
  output logic [1:0]             O_DITHER,
  output logic                   O_FRAC_MODE,
  output logic [W_FRAC-1:0]      O_NUM,
  output logic [W_FRAC-1:0]      O_DEN,
  output logic                   O_FSK_EN,
  output logic                   O_CAL_START,
  output logic                   O_LOCK,
  output logic                   O_TEST_LOCK_OUT,
  output logic                   O_TEST_OE
);
  flk_top_st_t       s_r;
  flk_top_st_t       s_nxt;
  logic              locked;
  logic              le_rise;
  logic [3:0]        adr;
  logic              ref_tick;
  logic              ref_rise;
  logic [W_RDIV-1:0] rdiv_eff;
  logic [W_NARROW-1:0] num_lo;
  logic [W_NARROW-1:0] den_lo;

  flk_lock_det #(
    .IDLE_MAX (IDLE_MAX)
  ) u_lock (
    .i_clk    (I_CLK),
    .i_srst   (I_SRST),
    .i_ref    (s_r.pd_ref),
    .i_fb     (I_FB_PULSE),
    .i_win    (s_r.ctl.win),
    .o_locked (locked)
  );

  // decode, write, reference path and applied modulator settings
  always_comb begin
    s_nxt    = s_r;
    le_rise  = I_SER_LE && !s_r.le_q;
    adr      = s_r.sh[3:0];
    ref_rise = I_REF_IN && !s_r.ref_q;
    ref_tick = I_REF_IN != s_r.ref_q;
    num_lo   = s_r.num[W_NARROW-1:0];
    den_lo   = s_r.den[W_NARROW-1:0];
    // zero would stall the divider, so it acts as one
    rdiv_eff = (s_r.rdiv == '0) ? RST_RDIV : s_r.rdiv; // RULE18
    s_nxt.sclk_q = I_SER_CLK;
    s_nxt.le_q   = I_SER_LE;
    s_nxt.ref_q  = I_REF_IN;
    s_nxt.cal    = 1'b0;
    if (I_SER_CLK && !s_r.sclk_q) begin
      s_nxt.sh = {s_r.sh[W_WORD-2:0], I_SER_DATA};
    end
    if (le_rise) begin
      unique case (adr)
        ADR_CTL: s_nxt.ctl = flk_ctl_t'(s_r.sh[F_CTL +: $bits(flk_ctl_t)]);
        ADR_DEN: s_nxt.den = s_r.sh[F_DEN +: W_FRAC]; // RULE16
        ADR_R1: begin
          s_nxt.rdiv = s_r.sh[F_RDIV +: W_RDIV];
          s_nxt.num[W_FRAC-1 -: W_NUMH] = s_r.sh[F_NUMH +: W_NUMH]; // RULE19
        end
        ADR_R0: s_nxt.num[W_NUML-1:0] = s_r.sh[F_NUML +: W_NUML]; // RULE19
        default: ;
      endcase
      // rewriting the same value still recalibrates
      if ((adr == ADR_R0 || adr == ADR_R1) && I_VCO_INTERNAL) begin
        s_nxt.cal = 1'b1;                  // RULE17
      end
    end
    // doubled reference skips the divider entirely
    s_nxt.pd_ref = 1'b0;
    if (s_r.ctl.dbl) begin
      s_nxt.pd_ref = ref_tick;             // RULE2
      s_nxt.rcnt   = '0;
    end else if (ref_rise) begin
      if (s_r.rcnt + 12'h001 >= rdiv_eff) begin
        s_nxt.pd_ref = 1'b1;               // RULE18
        s_nxt.rcnt   = '0;
      end else begin
        s_nxt.rcnt = s_r.rcnt + 12'h001;
      end
    end
    // mode bits land on a cycle boundary; divider words are untouched
    if (s_r.pd_ref) begin
      s_nxt.ord_a  = s_r.ctl.ord;          // RULE22
      s_nxt.dither_a = s_r.ctl.dither;
      s_nxt.wide_a = s_r.ctl.wide;
    end
    // illegal orders fall back to integer mode
    s_nxt.ord_o = (s_r.ord_a > ORD_MAX) ? ORD_INT : s_r.ord_a; // RULE5
    s_nxt.frac  = s_r.ord_a != ORD_INT && s_r.ord_a <= ORD_MAX;
    s_nxt.dither_o = (s_r.ord_a <= ORD_FIRST || s_r.ord_a > ORD_MAX) ?
                     DITHER_OFF : s_r.dither_a; // RULE6 RULE7
    if (!s_nxt.frac) begin
      s_nxt.num_o = '0;                    // RULE16
      s_nxt.den_o = '0;
    end else if (s_r.wide_a) begin
      s_nxt.num_o = s_r.num;               // RULE3
      s_nxt.den_o = s_r.den;
    end else begin
      s_nxt.num_o = {{(W_FRAC-W_NARROW){1'b0}}, num_lo}; // RULE3
      s_nxt.den_o = {{(W_FRAC-W_NARROW){1'b0}}, den_lo};
    end
    // test pin: analog and diagnostic modes have no source here
    s_nxt.tst    = 1'b0;
    s_nxt.tst_oe = s_r.ctl.test_out_select != MUX_HIZ &&
                   s_r.ctl.test_out_select <= MUX_DIAG_END;
    unique case (s_r.ctl.test_out_select)
      MUX_HIGH: s_nxt.tst = 1'b1;
      MUX_LD:   s_nxt.tst = locked;        // RULE20
      MUX_LDN:  s_nxt.tst = !locked;
      MUX_LDOD: s_nxt.tst_oe = !locked;    // RULE20
      default:  s_nxt.tst = 1'b0;
    endcase
    if (I_SRST) begin
      s_nxt        = '0;
      s_nxt.ctl    = RST_CTL;
      s_nxt.rdiv   = RST_RDIV;
      s_nxt.den    = RST_DEN;
      s_nxt.dither_a = DITHER_OFF;
      s_nxt.dither_o = DITHER_OFF;
      s_nxt.wide_a = RST_CTL.wide;
    end
  end

  always_ff @(posedge I_CLK) begin
    s_r <= s_nxt;
  end

  // outputs straight from state
  assign O_PUMP_POL      = s_r.ctl.pol;    // RULE1
  assign O_PUMP_TRI      = s_r.ctl.tri_st; // RULE10
  assign O_FSK_EN        = s_r.ctl.fsk;    // RULE15
  assign O_PD_REF        = s_r.pd_ref;
  assign O_MOD_ORDER     = s_r.ord_o;
  assign O_DITHER        = s_r.dither_o;
  assign O_FRAC_MODE     = s_r.frac;
  assign O_NUM           = s_r.num_o;
  assign O_DEN           = s_r.den_o;
  assign O_CAL_START     = s_r.cal;
  assign O_LOCK          = locked;
  assign O_TEST_LOCK_OUT = s_r.tst;
  assign O_TEST_OE       = s_r.tst_oe;

  property p_ctl_write;
    @(posedge I_CLK) disable iff (I_SRST)
    (I_SER_LE && !s_r.le_q && s_r.sh[3:0] == ADR_CTL) |=>
      O_PUMP_POL == $past(s_r.sh[F_CTL]) &&
      O_PUMP_TRI == $past(s_r.sh[F_CTL + 8]);
  endproperty
  a_ctl_write: assert property (p_ctl_write) // RULE1
    else $error("polarity or tri-state not taken from write");

  property p_cal;
    @(posedge I_CLK) disable iff (I_SRST)
    (I_SER_LE && !s_r.le_q && s_r.sh[3:1] == 3'h0 && I_VCO_INTERNAL)
      |=> O_CAL_START ##1 !O_CAL_START;
  endproperty
  a_cal: assert property (p_cal) // RULE17
    else $error("divider write did not pulse calibration");

  property p_dbl;
    @(posedge I_CLK) disable iff (I_SRST)
    (s_r.ctl.dbl && I_REF_IN != s_r.ref_q) |=> O_PD_REF;
  endproperty
  a_dbl: assert property (p_dbl) // RULE2
    else $error("doubled reference edge lost");

  property p_dither_off;
    @(posedge I_CLK) disable iff (I_SRST)
    (O_MOD_ORDER <= ORD_FIRST) |-> O_DITHER == DITHER_OFF;
  endproperty
  a_dither_off: assert property (p_dither_off) // RULE6
    else $error("dither active in integer or first order");

  property p_int;
    @(posedge I_CLK) disable iff (I_SRST)
    !O_FRAC_MODE |-> O_NUM == '0 && O_DEN == '0 && O_MOD_ORDER == ORD_INT;
  endproperty
  a_int: assert property (p_int) // RULE16
    else $error("fraction words applied in integer mode");

  property p_narrow;
    @(posedge I_CLK) disable iff (I_SRST)
    (!s_r.wide_a) |=> O_NUM[W_FRAC-1:W_NARROW] == '0 &&
                      O_DEN[W_FRAC-1:W_NARROW] == '0;
  endproperty
  a_narrow: assert property (p_narrow) // RULE3
    else $error("upper fraction bits used in narrow mode");
endmodule : flk_top

// *** test/flk_vco_model.sv ***
// flk_vco_model: far-side stand-in that answers each reference pulse
// with a feedback pulse i_lag cycles later; assumes one clock, I_CLK.
module flk_vco_model (
  input  wire logic       i_clk,
  input  wire logic       i_pd_ref,
  input  wire logic [1:0] i_lag,
  output logic            o_fb
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] dly_r = 3'h0;
  // delay line; lag 0 answers in the reference's own cycle
  always @(posedge i_clk) begin
    dly_r <= {dly_r[1:0], i_pd_ref};
  end
  // slow answers model a loop that drifted out of the window
  assign o_fb = (i_lag == 2'h0) ? i_pd_ref : dly_r[i_lag - 2'h1];
endmodule : flk_vco_model

// *** test/tb_top.sv ***
// tb_top: self-checking bench for flk_top, serial writes, reference
// stimulus and a feedback model; assumes the flk_pkg word layout.
module tb_top;
  import flk_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [21:0] NUMV = 22'h2AAAAA;
  logic I_CLK = 1'b0, I_SRST = 1'b1, I_SER_CLK = 1'b0, I_SER_DATA = 1'b0;
  logic I_SER_LE = 1'b0, I_REF_IN = 1'b0, I_VCO_INTERNAL = 1'b1;
  logic I_FB_PULSE, O_PUMP_POL, O_PUMP_TRI, O_PD_REF, O_FRAC_MODE;
  logic O_FSK_EN, O_CAL_START, O_LOCK, O_TEST_LOCK_OUT, O_TEST_OE;
  logic [2:0] O_MOD_ORDER;
  logic [1:0] O_DITHER;
  logic [21:0] O_NUM, O_DEN;
  logic [1:0] lag = 2'h0;
  logic ref_en = 1'b0, rcnt = 1'b0, cal1, cal2;
  flk_ctl_t cfg = RST_CTL;
  int mismatches = 0, cmp_count = 0, gap;

  flk_top #(.IDLE_MAX(16'h0028)) u_flk_top (.I_CLK, .I_SRST, .I_SER_CLK,
    .I_SER_DATA, .I_SER_LE, .I_REF_IN, .I_FB_PULSE, .I_VCO_INTERNAL,
    .O_PUMP_POL, .O_PUMP_TRI, .O_PD_REF, .O_MOD_ORDER, .O_DITHER,
    .O_FRAC_MODE, .O_NUM, .O_DEN, .O_FSK_EN, .O_CAL_START, .O_LOCK,
    .O_TEST_LOCK_OUT, .O_TEST_OE);
  flk_vco_model u_flk_vco_model (.i_clk(I_CLK), .i_pd_ref(O_PD_REF),
    .i_lag(lag), .o_fb(I_FB_PULSE));

  always #50 I_CLK = ~I_CLK;
  // reference toggles every two cycles, the slowest legal pace is longer
  always @(posedge I_CLK) begin
    if (ref_en) begin
      rcnt <= ~rcnt;
      if (rcnt) I_REF_IN <= ~I_REF_IN;
    end
  end

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  // msb first, one shift per serial clock high, latch after bit 0
  task automatic wr(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      @(posedge I_CLK);
      I_SER_DATA <= w[i];
      I_SER_CLK  <= 1'b1;
      @(posedge I_CLK);
      I_SER_CLK  <= 1'b0;
    end
    @(posedge I_CLK);
    I_SER_LE <= 1'b1;
    @(posedge I_CLK);
    I_SER_LE <= 1'b0;
    // the calibration pulse stands for the cycle after the commit edge
    #1 cal1 = O_CAL_START;
    @(posedge I_CLK);
    #1 cal2 = O_CAL_START;
  endtask : wr

  task automatic wctl();
    wr({11'h0, cfg, ADR_CTL});
  endtask : wctl

  task automatic wr1(input logic [11:0] r);
    wr({9'h0, NUMV[21:15], r, ADR_R1});
  endtask : wr1

  // bounded wait for the next reference pulse, gap holds the cycles
  task automatic waitpd(input int lim);
    int k;
    k = 0;
    do begin
      @(posedge I_CLK);
      #1 k++;
    end while (O_PD_REF !== 1'b1 && k < lim);
    if (O_PD_REF !== 1'b1) begin
      mismatches++;
      summarize();
    end
    gap = k;
  endtask : waitpd

  task automatic settle();
    waitpd(100);
    repeat (3) @(posedge I_CLK);
    #1;
  endtask : settle

  // stop the reference so no pulse is in flight when the lag changes
  task automatic setlag(input logic [1:0] l);
    @(posedge I_CLK);
    ref_en <= 1'b0;
    repeat (12) @(posedge I_CLK);
    lag    <= l;
    ref_en <= 1'b1;
  endtask : setlag

  task automatic t_frac();
    wr({6'h0, 22'h3FFFFF, ADR_DEN});
    wr1(12'h001);
    wr({13'h0, NUMV[14:0], ADR_R0});
    cfg.ord = 3'h3;
    wctl();
    repeat (6) @(posedge I_CLK);
    #1 chk("order held", 0, O_MOD_ORDER);
    ref_en <= 1'b1;
    settle();
    chk("order", 3, O_MOD_ORDER);
    chk("den", 22'h3FFFFF, O_DEN);
    chk("num", NUMV, O_NUM);
    cfg.wide = 1'b0;
    wctl();
    settle();
    chk("den narrow", 22'h3FF, O_DEN);
    chk("num narrow", 22'h2AA, O_NUM);
    cfg.ord = ORD_INT;
    wctl();
    settle();
    chk("den int", 0, O_DEN);
    chk("num int", 0, O_NUM);
    $display("test frac done");
  endtask : t_frac

  task automatic t_ctl();
    cfg.pol    = 1'b1;
    cfg.tri_st = 1'b1;
    cfg.fsk    = 1'b1;
    cfg.test_out_select    = MUX_HIGH;
    wctl();
    chk("pol", 1, O_PUMP_POL);
    chk("tri", 1, O_PUMP_TRI);
    chk("fsk", 1, O_FSK_EN);
    chk("pin high", 1, O_TEST_LOCK_OUT);
    chk("pin high oe", 1, O_TEST_OE);
    cfg = RST_CTL;
    wctl();
    chk("pol", 0, O_PUMP_POL);
    chk("tri", 0, O_PUMP_TRI);
    chk("fsk", 0, O_FSK_EN);
    chk("pin hiz oe", 0, O_TEST_OE);
    $display("test ctl done");
  endtask : t_ctl

  // only orders 2 to 4 get dither, the others keep it off
  task automatic t_ord();
    for (int o = 0; o < 8; o++) begin
      cfg.ord  = 3'(o);
      cfg.dither = (o >= 2 && o <= 4) ? 2'(o - 2) : DITHER_OFF;
      wctl();
      settle();
      chk("order", (o <= 4) ? o : 0, O_MOD_ORDER);
      chk("frac", (o >= 1 && o <= 4), O_FRAC_MODE);
      chk("dither", cfg.dither, O_DITHER);
    end
    $display("test order done");
  endtask : t_ord

  task automatic t_cal();
    for (int i = 0; i < 2; i++) begin
      wr({13'h0, NUMV[14:0], ADR_R0});
      chk("cal r0", 1, cal1);
      chk("cal end", 0, cal2);
    end
    wr1(12'h001);
    chk("cal r1", 1, cal1);
    wctl();
    chk("cal ctl", 0, cal1);
    @(posedge I_CLK);
    I_VCO_INTERNAL <= 1'b0;
    wr1(12'h001);
    chk("cal ext", 0, cal1);
    @(posedge I_CLK);
    I_VCO_INTERNAL <= 1'b1;
    wr({11'h0, 17'h00001, 4'h4});
    chk("unmapped", 0, O_PUMP_POL);
    $display("test cal done");
  endtask : t_cal

  task automatic t_ref();
    logic [11:0] rv [4] = '{12'h001, 12'hFFF, 12'h000, 12'h003};
    int ev [4] = '{4, 16380, 4, 12};
    for (int i = 0; i < 4; i++) begin
      wr1(rv[i]);
      repeat (3) waitpd(20000);
      chk("ref gap", ev[i], gap);
    end
    cfg.dbl = 1'b1;
    wctl();
    repeat (3) waitpd(100);
    chk("doubled gap", 2, gap);
    cfg.dbl = 1'b0;
    cfg.test_out_select = MUX_LD;
    wctl();
    $display("test ref done");
  endtask : t_ref

  task automatic t_lock();
    wr1(12'h002);
    setlag(2'h0);
    repeat (6) waitpd(100);
    chk("lock", 1, O_LOCK);
    chk("pin", 1, O_TEST_LOCK_OUT);
    chk("pin oe", 1, O_TEST_OE);
    setlag(2'h1);
    for (int w = 0; w < 8; w++) begin
      cfg.win = 3'(w);
      wctl();
      chk("lock edge", 1, O_LOCK);
    end
    setlag(2'h3);
    repeat (2) waitpd(100);
    repeat (4) @(posedge I_CLK);
    #1 chk("lock lost", 0, O_LOCK);
    chk("pin", 0, O_TEST_LOCK_OUT);
    setlag(2'h0);
    repeat (4) waitpd(100);
    setlag(2'h3);
    waitpd(100);
    setlag(2'h0);
    repeat (4) waitpd(100);
    repeat (3) @(posedge I_CLK);
    #1 chk("lock four", 0, O_LOCK);
    waitpd(100);
    repeat (3) @(posedge I_CLK);
    #1 chk("lock five", 1, O_LOCK);
    cfg.test_out_select = MUX_LDN;
    wctl();
    chk("pin inv", 0, O_TEST_LOCK_OUT);
    cfg.test_out_select = MUX_LDOD;
    wctl();
    chk("pin od oe", 0, O_TEST_OE);
    ref_en <= 1'b0;
    repeat (60) @(posedge I_CLK);
    #1 chk("no ref", 0, O_LOCK);
    chk("pin od pull", 1, O_TEST_OE);
    chk("pin od low", 0, O_TEST_LOCK_OUT);
    $display("test lock done");
  endtask : t_lock

  initial begin
    repeat (20) @(posedge I_CLK);
    I_SRST <= 1'b0;
    @(posedge I_CLK);
    #1 chk("dither rst", DITHER_OFF, O_DITHER);
    chk("order rst", 0, O_MOD_ORDER);
    t_frac();
    t_ctl();
    t_ord();
    t_cal();
    t_ref();
    t_lock();
    summarize();
  end
endmodule : tb_top
